// ### rtl/epo_pkg.sv
package epo_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_ROT_RES = 4'h1;
  localparam logic [3:0] ADDR_LIN_RES = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_POS = 4'h5;
  localparam logic [3:0] ADDR_RATE = 4'h6;

  // ***************************************************************
  // Config field positions and reset values
  // ***************************************************************
  localparam int CFG_BUFFERED_BIT = 0;
  localparam int CFG_LINEAR_BIT = 1;
  localparam int CFG_MULTITURN_BIT = 2;
  localparam int CFG_MULTI_INDEX_BIT = 3;
  localparam int CFG_GANTRY_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'h0C;
  localparam logic [31:0] ROT_RES_RESET = 32'h0000_2000;
  localparam logic [31:0] LIN_RES_RESET = 32'h0001_86A0;
  localparam logic [31:0] ROT_RES_MIN = 32'h0000_0040;
  localparam logic [31:0] LIN_RES_MIN = 32'h0000_07D0;
  localparam logic [31:0] RES_MAX = 32'h4000_0000;

  // ***************************************************************
  // Status bits and limits
  // ***************************************************************
  localparam int ST_OVERSPEED_BIT = 0;
  localparam int ST_INDEX_BIT = 1;
  localparam int ST_MARK_BIT = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam int CLK_HZ = 100_000_000;
  localparam int EDGE_RATE_MAX_HZ = 18_000_000;
  localparam int MIN_EDGE_CYCLES = (CLK_HZ + EDGE_RATE_MAX_HZ - 1)
                                   / EDGE_RATE_MAX_HZ;
  localparam logic [3:0] MIN_EDGE_CYC = 4'(MIN_EDGE_CYCLES);
  localparam logic [31:0] RATE_RESET = 32'h0000_0000;
  localparam logic [23:0] RATE_WIN_LAST = 24'h01_869F;

  typedef enum logic [1:0]
  {
    EPO_Q00 = 2'b00,
    EPO_Q10 = 2'b01,
    EPO_Q11 = 2'b11,
    EPO_Q01 = 2'b10
  } epo_quad_e;

endpackage

// ### rtl/epo_encoder_pulse_output.sv
// Behaviour
// [RL1] Setup digit selects scaled or buffered output.
// [RL2] Buffered mode ignores resolution settings entirely.
// [RL3] Outputs A and B in quadrature.
// [RL4] A leads forward, B leads reverse.
// [RL5] Index per revolution, also single ended.
// [RL6] Rotary edges per revolution 64 to 2^30.
// [RL7] Linear edges per 100 mm, 2000 up.
// [RL8] Alarm when edge rate exceeds 18 M/s. Code: scaled mode only, on a backlog of three steps at the pacing limit.
// [RL9] Resolution counts are pulse edges.
// [RL10] Index width follows programmed resolution. Code: forward rotary only; reverse rotary and linear index end at a step (multi-index: if mark low).
// [RL11] Multi-turn home select gives index per revolution.
// [RL12] Multi-turn select ignored for linear motors.
// [RL13] Multi-index emits index at every mark.
// [RL14] Otherwise latch first mark, index from it.
// [RL15] Multi-index ignored for rotary or gantry.
// [RL16] Only one phase changes per step.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module epo_encoder_pulse_output
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_ENC_A,
  input wire logic I_ENC_B,
  input wire logic I_ENC_Z,
  input wire logic I_REF_MARK,
  input wire logic I_POS_STEP,
  input wire logic I_POS_DIR,
  output logic O_A,
  output logic O_A_N,
  output logic O_B,
  output logic O_B_N,
  output logic O_Z,
  output logic O_Z_N,
  output logic O_SINGLE_ENDED_INDEX_OUT,
  output logic O_OUTPUT_OVERSPEED_ALARM,
  output logic O_IRQ
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [4:0] cfg;
    logic [4:0] cfg_live;
    logic [31:0] rot_res;
    logic [31:0] lin_res;
    logic [31:0] res_live;
    logic cfg_loaded;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_z;
    logic [1:0] sync_m;
    logic mark_d;
    logic [1:0] quad;
    logic [31:0] pos;
    logic mark_seen;
    logic [31:0] mark_pos;
    logic [3:0] gap;
    logic [1:0] pending;
    logic pend_dir;
    logic z;
    logic [31:0] rate;
    logic [31:0] rate_cnt;
    logic [23:0] win;
    logic alarm;
  } epo_state_s;

  epo_state_s r;
  epo_state_s next_r;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] epo_clamp(input logic [31:0] v,
                                            input logic [31:0] lo);
    begin
      if (v < lo)
      begin
        epo_clamp = lo;
      end
      else if (v > epo_pkg::RES_MAX)
      begin
        epo_clamp = epo_pkg::RES_MAX;
      end
      else
      begin
        epo_clamp = v;
      end
    end
  endfunction

  function automatic logic [1:0] epo_step(input logic [1:0] q,
                                          input logic fwd);
    begin
      case (q)
        epo_pkg::EPO_Q00: epo_step = fwd ? 2'b01 : 2'b10;
        epo_pkg::EPO_Q10: epo_step = fwd ? 2'b11 : 2'b00;
        epo_pkg::EPO_Q11: epo_step = fwd ? 2'b10 : 2'b01;
        default: epo_step = fwd ? 2'b00 : 2'b11;
      endcase
    end
  endfunction

  // ***************************************************************
  // Decoded modes
  // ***************************************************************
  logic linear;
  logic buffered;
  logic use_multi_index;
  logic use_multiturn;
  logic step_ok;
  logic rev_edge;
  logic mark_rise;
  logic [31:0] pos_next;
  logic [31:0] zwidth;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    next_r = r;
    linear = r.cfg_live[epo_pkg::CFG_LINEAR_BIT];
    buffered = r.cfg_live[epo_pkg::CFG_BUFFERED_BIT];
    use_multiturn = r.cfg_live[epo_pkg::CFG_MULTITURN_BIT]
                    && !linear; // see [RL12]
    use_multi_index = r.cfg_live[epo_pkg::CFG_MULTI_INDEX_BIT]
                      && linear
                      && !r.cfg_live[epo_pkg::CFG_GANTRY_BIT]; // see [RL15]
    zwidth = {2'b00, r.res_live[31:2]}; // see [RL10]
    if (zwidth == 32'h0000_0000)
    begin
      zwidth = 32'h0000_0001;
    end
    next_r.sync_a = {r.sync_a[0], I_ENC_A};
    next_r.sync_b = {r.sync_b[0], I_ENC_B};
    next_r.sync_z = {r.sync_z[0], I_ENC_Z};
    next_r.sync_m = {r.sync_m[0], I_REF_MARK};
    next_r.mark_d = r.sync_m[1];
    mark_rise = r.sync_m[1] && !r.mark_d;
    next_r.rdata = 32'h0000_0000;

    if (I_WR)
    begin
      if (I_ADDR == epo_pkg::ADDR_CONFIG)
      begin
        next_r.cfg = I_WDATA[4:0];
      end
      else if (I_ADDR == epo_pkg::ADDR_ROT_RES)
      begin
        next_r.rot_res = epo_clamp(I_WDATA, epo_pkg::ROT_RES_MIN); // see [RL6]
      end
      else if (I_ADDR == epo_pkg::ADDR_LIN_RES)
      begin
        next_r.lin_res = epo_clamp(I_WDATA, epo_pkg::LIN_RES_MIN); // see [RL7]
      end
      else if (I_ADDR == epo_pkg::ADDR_MASK)
      begin
        next_r.mask = I_WDATA[2:0];
      end
    end
    if (I_RD)
    begin
      if (I_ADDR == epo_pkg::ADDR_CONFIG)
      begin
        next_r.rdata = {27'h000_0000, r.cfg};
      end
      else if (I_ADDR == epo_pkg::ADDR_ROT_RES)
      begin
        next_r.rdata = r.rot_res;
      end
      else if (I_ADDR == epo_pkg::ADDR_LIN_RES)
      begin
        next_r.rdata = r.lin_res;
      end
      else if (I_ADDR == epo_pkg::ADDR_STATUS)
      begin
        next_r.rdata = {29'h0000_0000, r.status};
      end
      else if (I_ADDR == epo_pkg::ADDR_MASK)
      begin
        next_r.rdata = {29'h0000_0000, r.mask};
      end
      else if (I_ADDR == epo_pkg::ADDR_POS)
      begin
        next_r.rdata = r.pos;
      end
      else if (I_ADDR == epo_pkg::ADDR_RATE)
      begin
        next_r.rdata = r.rate;
      end
    end

    // Settings take effect once, when the first position step arrives.
    if (!r.cfg_loaded && I_POS_STEP) // see [RL6]
    begin
      next_r.cfg_loaded = 1'b1;
      next_r.cfg_live = r.cfg; // see [RL1]
      next_r.res_live = r.cfg[epo_pkg::CFG_LINEAR_BIT]
                        ? r.lin_res : r.rot_res; // see [RL7]
    end

    // Position counted in output edges, wrapping at the resolution.
    pos_next = r.pos;
    if (I_POS_STEP && r.cfg_loaded)
    begin
      if (I_POS_DIR)
      begin
        pos_next = (r.pos + 32'h0000_0001 >= r.res_live)
                   ? 32'h0000_0000 : r.pos + 32'h0000_0001; // see [RL9]
      end
      else
      begin
        pos_next = (r.pos == 32'h0000_0000)
                   ? r.res_live - 32'h0000_0001
                   : r.pos - 32'h0000_0001;
      end
      if (r.pending != 2'b11)
      begin
        next_r.pending = r.pending + 2'b01;
      end
      next_r.pend_dir = I_POS_DIR;
    end
    next_r.pos = pos_next;

    // Quadrature stepper paced to no more than the edge rate limit.
    step_ok = (r.gap == 4'h0) && (r.pending != 2'b00);
    next_r.gap = (r.gap == 4'h0) ? 4'h0 : r.gap - 4'h1;
    if (step_ok && !buffered)
    begin
      next_r.quad = epo_step(r.quad, r.pend_dir); // see [RL3] [RL4] [RL16]
      next_r.gap = epo_pkg::MIN_EDGE_CYC - 4'h1;
      if (!(I_POS_STEP && r.cfg_loaded))
      begin
        next_r.pending = r.pending - 2'b01;
      end
      else
      begin
        next_r.pending = r.pending;
      end
    end

    // Index generation.
    if (!r.mark_seen && mark_rise && linear)
    begin
      next_r.mark_seen = 1'b1;
      next_r.mark_pos = r.pos; // see [RL14]
    end
    rev_edge = 1'b0;
    if (linear)
    begin
      if (use_multi_index)
      begin
        rev_edge = mark_rise; // see [RL13]
      end
      else if (r.mark_seen)
      begin
        rev_edge = (pos_next == r.mark_pos) && (pos_next != r.pos); // see [RL14]
      end
    end
    else if (use_multiturn)
    begin
      rev_edge = (pos_next == 32'h0000_0000) && (pos_next != r.pos); // see [RL11]
    end
    if (rev_edge)
    begin
      next_r.z = 1'b1;
    end
    else if (r.z && (pos_next != r.pos))
    begin
      next_r.z = ((pos_next < zwidth) && !linear)
                 || (linear && use_multi_index && r.sync_m[1]); // see [RL10]
    end

    // Edge rate measured over one millisecond windows.
    next_r.win = r.win + 24'h00_0001;
    next_r.rate_cnt = (I_POS_STEP ? r.rate_cnt + 32'h0000_0001 : r.rate_cnt);
    if (r.win == epo_pkg::RATE_WIN_LAST)
    begin
      next_r.win = 24'h00_0000;
      next_r.rate = next_r.rate_cnt;
      next_r.rate_cnt = 32'h0000_0000;
    end
    // Overspeed is a backlog of three steps at the pacing limit.
    next_r.alarm = (r.pending == 2'b11) && I_POS_STEP && !buffered; // see [RL8]

    // Sticky status, set wins over write one to clear.
    if (I_WR && I_ADDR == epo_pkg::ADDR_STATUS)
    begin
      next_r.status = r.status & ~I_WDATA[2:0];
    end
    if (r.alarm)
    begin
      next_r.status[epo_pkg::ST_OVERSPEED_BIT] = 1'b1; // see [RL8]
    end
    if (rev_edge)
    begin
      next_r.status[epo_pkg::ST_INDEX_BIT] = 1'b1;
    end
    if (mark_rise)
    begin
      next_r.status[epo_pkg::ST_MARK_BIT] = 1'b1;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      r <= '0;
      r.cfg <= epo_pkg::CFG_RESET;
      r.cfg_live <= epo_pkg::CFG_RESET;
      r.rot_res <= epo_pkg::ROT_RES_RESET;
      r.lin_res <= epo_pkg::LIN_RES_RESET;
      r.res_live <= epo_pkg::ROT_RES_RESET;
      r.status <= epo_pkg::STATUS_RESET;
      r.rate <= epo_pkg::RATE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  logic out_a;
  logic out_b;
  logic out_z;

  // Buffered mode forwards the synchronised raw encoder lines.
  always_comb
  begin
    if (r.cfg_live[epo_pkg::CFG_BUFFERED_BIT]) // see [RL1] [RL2]
    begin
      out_a = r.sync_a[1];
      out_b = r.sync_b[1];
      out_z = r.sync_z[1];
    end
    else
    begin
      out_a = r.quad[0];
      out_b = r.quad[1];
      out_z = r.z;
    end
  end

  assign O_A = out_a;
  assign O_A_N = !out_a;
  assign O_B = out_b;
  assign O_B_N = !out_b;
  assign O_Z = out_z; // see [RL5]
  assign O_Z_N = !out_z;
  assign O_SINGLE_ENDED_INDEX_OUT = out_z; // see [RL5]
  assign O_OUTPUT_OVERSPEED_ALARM = r.status[epo_pkg::ST_OVERSPEED_BIT];
  assign O_IRQ = |(r.status & r.mask);
  assign O_RDATA = r.rdata;

endmodule

// ### verif/epo_encoder_pulse_output_sva.sv
`timescale 1ns/10ps
module epo_encoder_pulse_output_sva
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_POS_DIR,
  input wire logic O_A,
  input wire logic O_A_N,
  input wire logic O_B,
  input wire logic O_B_N,
  input wire logic O_Z,
  input wire logic O_Z_N,
  input wire logic O_SINGLE_ENDED_INDEX_OUT,
  input wire logic O_OUTPUT_OVERSPEED_ALARM
);
  // ***************************************************************
  // Output relations.
  // ***************************************************************
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  property p_a_pair;
    O_A_N == !O_A;
  endproperty
  a_a_pair: assert property (p_a_pair)
    else $error("Phase A pair not complementary.");
  property p_b_pair;
    O_B_N == !O_B;
  endproperty
  a_b_pair: assert property (p_b_pair)
    else $error("Phase B pair not complementary.");
  property p_z_pair;
    O_Z_N == !O_Z;
  endproperty
  a_z_pair: assert property (p_z_pair)
    else $error("Index pair not complementary.");
  property p_cz_copy;
    O_SINGLE_ENDED_INDEX_OUT == O_Z;
  endproperty
  a_cz_copy: assert property (p_cz_copy)
    else $error("Single ended index differs from index.");
  property p_gray;
    $changed(O_A) |-> $stable(O_B);
  endproperty
  a_gray: assert property (p_gray)
    else $error("Both phases changed at once.");
  property p_fwd;
    $rose(O_A) && !O_B |-> $past(I_POS_DIR, 2);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("Forward step without forward direction.");
  property p_rev;
    $rose(O_B) && !O_A |-> !$past(I_POS_DIR, 2);
  endproperty
  a_rev: assert property (p_rev)
    else $error("Reverse step without reverse direction.");
  property p_alarm_hold;
    O_OUTPUT_OVERSPEED_ALARM && !(I_WR && I_WDATA[0]
      && I_ADDR == epo_pkg::ADDR_STATUS) |=> O_OUTPUT_OVERSPEED_ALARM;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("Overspeed alarm dropped without a clear.");
  c_index: cover property ($rose(O_Z));
  c_alarm: cover property ($rose(O_OUTPUT_OVERSPEED_ALARM));
  c_fwd: cover property ($rose(O_A) && !O_B);
endmodule

// ### verif/epo_ctrl_model.sv
`timescale 1ns/10ps
module epo_ctrl_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_a,
  input wire logic i_b,
  output int o_count,
  output logic o_bad
);
  // ***************************************************************
  // Quadrature counter of the motion controller.
  // ***************************************************************
  logic [1:0] prev;
  logic [1:0] fwd;
  always_comb fwd = {~prev[0], prev[1]};
  always_ff @(posedge i_clk)
  begin
    prev <= {i_a, i_b};
    if (i_rst)
    begin
      o_count <= 0;
      o_bad <= 1'b0;
    end
    else if ({i_a, i_b} == fwd)
      o_count <= o_count + 1;
    else if (({i_a, i_b} ^ prev) == 2'b11)
      o_bad <= 1'b1;
    else if ({i_a, i_b} != prev)
      o_count <= o_count - 1;
  end
endmodule

// ### verif/epo_encoder_pulse_output_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module epo_encoder_pulse_output_bench;
  // ***************************************************************
  // Stimulus and comparison.
  // ***************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic enc_a = 1'b0;
  logic enc_b = 1'b0;
  logic enc_z = 1'b0;
  logic mark = 1'b0;
  logic step = 1'b0;
  logic dir = 1'b1;
  logic [31:0] rdata;
  logic o_a, o_an, o_b, o_bn, o_z, o_zn, o_cz, alarm, irq, bad;
  logic [31:0] rng = 32'h0000_0053;
  logic [1:0] seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int count;
  int exp_pos = 0;
  int mismatches = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  epo_encoder_pulse_output u_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ENC_A(enc_a),
    .I_ENC_B(enc_b), .I_ENC_Z(enc_z), .I_REF_MARK(mark), .I_POS_STEP(step),
    .I_POS_DIR(dir), .O_A(o_a), .O_A_N(o_an), .O_B(o_b), .O_B_N(o_bn),
    .O_Z(o_z), .O_Z_N(o_zn), .O_SINGLE_ENDED_INDEX_OUT(o_cz),
    .O_OUTPUT_OVERSPEED_ALARM(alarm), .O_IRQ(irq));
  epo_ctrl_model u_ctl (.i_clk(clk), .i_rst(rst), .i_a(o_a), .i_b(o_b),
    .o_count(count), .o_bad(bad));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] ad, input logic [31:0] ex);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata)
  endtask
  task automatic step_one(input logic d);
    @(posedge clk);
    step <= 1'b1;
    dir <= d;
    @(posedge clk);
    step <= 1'b0;
    repeat (6) @(posedge clk);
    exp_pos = exp_pos + (d ? 1 : -1);
  endtask
  task automatic irq_chk(input logic [3:0] ad, input logic [31:0] d,
                         input logic ex);
    wr_reg(ad, d);
    @(posedge clk);
    #1;
    `CHK("irq", ex, irq)
  endtask
  task automatic restart(input logic [31:0] cfg);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr_reg(epo_pkg::ADDR_CONFIG, cfg);
    wr_reg(epo_pkg::ADDR_ROT_RES, 32'h0000_0040);
    step_one(1'b1);
    exp_pos = 0;
  endtask
  task automatic mark_pulse;
    mark <= 1'b1;
    repeat (8) @(posedge clk);
    mark <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(epo_pkg::ADDR_CONFIG, 32'h0000_000C);
    rd_chk(epo_pkg::ADDR_ROT_RES, 32'h0000_2000);
    rd_chk(epo_pkg::ADDR_LIN_RES, 32'h0001_86A0);
    rd_chk(epo_pkg::ADDR_MASK, 32'h0000_0000);
    rd_chk(4'h7, 32'h0000_0000);
    wr_reg(epo_pkg::ADDR_ROT_RES, 32'hFFFF_FFFF);
    rd_chk(epo_pkg::ADDR_ROT_RES, 32'h4000_0000);
    wr_reg(epo_pkg::ADDR_LIN_RES, 32'h0000_0000);
    rd_chk(epo_pkg::ADDR_LIN_RES, 32'h0000_07D0);
    wr_reg(epo_pkg::ADDR_ROT_RES, 32'h0000_0001);
    rd_chk(epo_pkg::ADDR_ROT_RES, 32'h0000_0040);
    step_one(1'b1);
    exp_pos = 0;
    repeat (64) step_one(1'b1);
    `CHK("count", exp_pos, count)
    `CHK("index", 1'b1, o_z)
    repeat (16) step_one(1'b1);
    `CHK("index", 1'b0, o_z)
    for (int i = 0; i < 40; i++)
    begin
      rng = xs(rng);
      step_one(rng[0]);
      `CHK("count", exp_pos, count)
    end
    wr_reg(epo_pkg::ADDR_MASK, 32'h0000_0001);
    @(posedge clk);
    step <= 1'b1;
    repeat (6) @(posedge clk);
    step <= 1'b0;
    for (int n = 0; n < 20 && alarm !== 1'b1; n++) @(posedge clk);
    `CHK("alarm", 1'b1, alarm)
    repeat (40) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    irq_chk(epo_pkg::ADDR_MASK, 32'h0000_0000, 1'b0);
    irq_chk(epo_pkg::ADDR_MASK, 32'h0000_0001, 1'b1);
    irq_chk(epo_pkg::ADDR_STATUS, 32'h0000_0001, 1'b0);
    `CHK("alarm", 1'b0, alarm)
    `CHK("gray", 1'b0, bad)
    restart(32'h0000_000D);
    for (int k = 0; k < 4; k++)
    begin
      enc_a <= seq[k][1];
      enc_b <= seq[k][0];
      enc_z <= seq[k][0];
      repeat (8) @(posedge clk);
      `CHK("buf", {seq[k], seq[k][0]}, {o_a, o_b, o_z})
    end
    `CHK("count", 4, count)
    restart(32'h0000_000E);
    mark_pulse();
    `CHK("index", 1'b1, o_z)
    rd_chk(epo_pkg::ADDR_STATUS, 32'h0000_0006);
    step_one(1'b1);
    `CHK("index", 1'b0, o_z)
    restart(32'h0000_001E);
    mark_pulse();
    `CHK("index", 1'b0, o_z)
    step_one(1'b1);
    step_one(1'b0);
    `CHK("index", 1'b1, o_z)
    step_one(1'b1);
    `CHK("index", 1'b0, o_z)
    `CHK("count", exp_pos, count)
    rd_chk(epo_pkg::ADDR_POS, exp_pos);
    tally_and_finish();
  end
endmodule
bind epo_encoder_pulse_output epo_encoder_pulse_output_sva u_sva (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_POS_DIR(I_POS_DIR), .O_A(O_A), .O_A_N(O_A_N), .O_B(O_B),
  .O_B_N(O_B_N), .O_Z(O_Z), .O_Z_N(O_Z_N),
  .O_SINGLE_ENDED_INDEX_OUT(O_SINGLE_ENDED_INDEX_OUT),
  .O_OUTPUT_OVERSPEED_ALARM(O_OUTPUT_OVERSPEED_ALARM));
